// [design/rsw_pkg.sv]
/*
  Constants for the reset source and watchdog controller: register map,
  field positions, reset values and timing figures.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
*/
package rsw_pkg;

  // Clock and timing figures, each kept in its own unit
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned PIN_MIN_PULSE_NS   = 900;   // Least low time on the reset pin
  localparam int unsigned DROP_MIN_PULSE_US  = 2;     // Least time below the trigger level
  localparam logic [15:0] PIN_MIN_CYC        =
    16'((PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DROP_MIN_CYC       =
    16'((DROP_MIN_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [4:0]  OFS_CAUSE   = 5'h00;   // reset_cause_flags
  localparam logic [4:0]  OFS_WDCTRL  = 5'h04;   // Watchdog control
  localparam logic [4:0]  OFS_WDKICK  = 5'h08;   // Watchdog restart strobe
  localparam logic [4:0]  OFS_CMPCTL  = 5'h0c;   // comparator_ctrl_stat
  localparam logic [4:0]  OFS_STATUS  = 5'h10;   // Block status

  // reset_cause_flags bit positions
  localparam int unsigned CAUSE_POR   = 0;   // powerup_reset_seen
  localparam int unsigned CAUSE_PIN   = 1;   // pin_reset_seen
  localparam int unsigned CAUSE_DROP  = 2;   // supply_drop_reset_seen
  localparam int unsigned CAUSE_WDOG  = 3;   // wdog_reset_seen
  localparam logic [3:0]  CAUSE_RESET = 4'h1;  // Power-up seen after reset

  // Watchdog control bit positions
  localparam int unsigned WD_EN       = 0;
  localparam int unsigned WD_IE       = 1;
  localparam int unsigned WD_IF       = 2;
  localparam int unsigned WD_CE       = 3;
  localparam int unsigned WD_PER_LSB  = 4;   // Four-bit period select in [7:4]

  // Comparator control and status bit positions
  localparam int unsigned CMP_BGSEL   = 0;   // comparator_bandgap_select
  localparam int unsigned ST_VREF     = 0;
  localparam int unsigned ST_DROP_EN  = 1;
  localparam int unsigned ST_LEVEL2   = 2;

  // Watchdog period table: base count doubled per select code
  localparam logic [20:0] WD_BASE_CYC = 21'h000800;  // 2K oscillator cycles
  localparam logic [3:0]  WD_MAX_SEL  = 4'h9;        // Ten selectable periods
  localparam logic [2:0]  CE_WINDOW   = 3'h4;        // Change window in clocks
  localparam logic [2:0]  DROP_OFF    = 3'h7;        // Level code that disables detection

endpackage : rsw_pkg

// [design/rsw_ctrl.sv]
/*
  Reset source combiner, start-up delay stretcher, reset cause flags,
  watchdog with reset or interrupt action, and voltage reference enable.
  Assumes fuses, converter enable, restart strobe and delay length come
  from logic on mclk; pin, supply monitor and 128 kHz oscillator inputs
  are asynchronous and are synchronised here.
*/
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module rsw_ctrl #(
  parameter int unsigned DLY_W = 16
) (
  // Clock and reset
  input  wire  logic                 mclk,
  input  wire  logic                 rst,
  // Avalon-MM register port
  input  wire  logic [4:0]           avs_address,
  input  wire  logic                 avs_read,
  input  wire  logic                 avs_write,
  input  wire  logic [31:0]          avs_writedata,
  input  wire  logic [3:0]           avs_byteenable,
  output logic       [31:0]          avs_readdata,
  output logic                       avs_waitrequest,
  // Asynchronous inputs from pin, supply monitors and oscillator
  input  wire  logic                 reset_pin_n,
  input  wire  logic                 supply_below_por,
  input  wire  logic                 supply_below_trigger,
  input  wire  logic                 wdog_osc_clk,
  // Configuration and strobes from the system clock domain
  input  wire  logic [2:0]           supply_drop_level_fuse,
  input  wire  logic                 wdog_safety_fuse,
  input  wire  logic                 wdog_restart_instr,
  input  wire  logic                 converter_enable,
  input  wire  logic [DLY_W-1:0]     startup_delay_period,
  // Reset and control outputs
  output logic                       internal_reset,
  output logic                       io_reset,
  output logic                       wdog_irq,
  output logic                       vref_enable,
  output logic                       supply_drop_enable,
  output logic [2:0]                 supply_drop_level
);
  import rsw_pkg::*;

  // Refuse delay widths beyond the 32-bit count that software and checks compare against;
  // the test runs at elaboration, so a bad build never reaches simulation
  if (DLY_W < 1 || DLY_W > 32) begin : g_bad_width
    $error("rsw_ctrl: DLY_W must lie between 1 and 32");
  end

  typedef struct packed {
    logic             pin_s1;
    logic             pin_s2;
    logic             por_s1;
    logic             por_s2;
    logic             bot_s1;
    logic             bot_s2;
    logic             osc_s1;
    logic             osc_s2;
    logic             osc_d;
    logic [15:0]      pin_cnt;
    logic             pin_act;
    logic [15:0]      drop_cnt;
    logic             drop_act;
    logic             wd_pulse;
    logic [DLY_W-1:0] dly_cnt;
    logic             int_rst;
    logic             io_rst;
    logic [3:0]       flags;
    logic             wd_en;
    logic             wd_ie;
    logic             wd_if;
    logic [3:0]       wd_per;
    logic [2:0]       ce_cnt;
    logic [20:0]      wd_cnt;
    logic             bgsel;
    logic             vref;
    logic             drop_en;
    logic [2:0]       level;
    logic             irq;
    logic             ack;
    logic [31:0]      rdata;
  } rsw_state_t;

  rsw_state_t st_reg;
  rsw_state_t st_next;

  // Time-out count for a period select; reserved codes use the longest period
  function automatic logic [20:0] rsw_limit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > WD_MAX_SEL) ? WD_MAX_SEL : sel;
    return WD_BASE_CYC << s;
  endfunction : rsw_limit

  // Register read mux, used only for the bus read data
  function automatic logic [31:0] rsw_read(input rsw_state_t s, input logic [4:0] a, input logic lvl2);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      OFS_CAUSE: begin
        d[3:0] = s.flags;                            // Upper bits stay zero
      end
      OFS_WDCTRL: begin
        d[WD_EN] = s.wd_en | s.flags[CAUSE_WDOG] | lvl2;
        d[WD_IE] = s.wd_ie;
        d[WD_IF] = s.wd_if;
        d[WD_CE] = (s.ce_cnt != 3'h0);
        d[WD_PER_LSB +: 4] = s.wd_per;
      end
      OFS_CMPCTL: begin
        d[CMP_BGSEL] = s.bgsel;
      end
      OFS_STATUS: begin
        d[ST_VREF] = s.vref;
        d[ST_DROP_EN] = s.drop_en;
        d[ST_LEVEL2] = lvl2;
      end
      default: begin
        d = 32'h0;                                   // Unmapped offsets read zero
      end
    endcase
    return d;
  endfunction : rsw_read

  logic lvl2;
  assign lvl2 = wdog_safety_fuse;

  // Next-state logic for the whole block
  always_comb begin
    logic        src;
    logic        drop_on;
    logic        wd_run;
    logic        wd_eff;
    logic        tick;
    logic        timeout;
    logic        wr;
    logic        wr_lo;
    logic        win;
    logic [31:0] wd_wd;
    src = 1'b0;
    drop_on = 1'b0;
    wd_run = 1'b0;
    wd_eff = 1'b0;
    tick = 1'b0;
    timeout = 1'b0;
    wr = 1'b0;
    wr_lo = 1'b0;
    win = 1'b0;
    wd_wd = avs_writedata;
    st_next = st_reg;

    // Two-stage synchronisers; only the second stage feeds logic, except the oscillator, whose third stage osc_d also feeds the edge detect
    st_next.pin_s1 = reset_pin_n;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.por_s1 = supply_below_por;
    st_next.por_s2 = st_reg.por_s1;
    st_next.bot_s1 = supply_below_trigger;
    st_next.bot_s2 = st_reg.bot_s1;
    st_next.osc_s1 = wdog_osc_clk;
    st_next.osc_s2 = st_reg.osc_s1;
    st_next.osc_d  = st_reg.osc_s2;
    tick = st_reg.osc_s2 & ~st_reg.osc_d;            // Oscillator rising edge

    // Pin reset qualifies only after the least low time
    if (st_reg.pin_s2) begin
      st_next.pin_cnt = 16'h0;
      st_next.pin_act = 1'b0;
    end else if (st_reg.pin_cnt >= PIN_MIN_CYC - 16'h1) begin
      st_next.pin_act = 1'b1;
    end else begin
      st_next.pin_cnt = st_reg.pin_cnt + 16'h1;
    end

    // Supply drop detection, gated by the level fuse; short dips are filtered
    drop_on = (supply_drop_level_fuse != DROP_OFF);
    st_next.drop_en = drop_on;
    st_next.level = supply_drop_level_fuse;          // Trigger level for the analog comparator
    if (!drop_on || !st_reg.bot_s2) begin
      st_next.drop_cnt = 16'h0;
      st_next.drop_act = 1'b0;
    end else if (st_reg.drop_cnt >= DROP_MIN_CYC - 16'h1) begin
      st_next.drop_act = 1'b1;
    end else begin
      st_next.drop_cnt = st_reg.drop_cnt + 16'h1;
    end

    // Any active source holds reset and reloads the delay; release after the count
    src = st_reg.por_s2 | st_reg.pin_act | st_reg.drop_act | st_reg.wd_pulse;
    st_next.io_rst = src;
    if (src) begin
      st_next.dly_cnt = startup_delay_period;
      st_next.int_rst = 1'b1;
    end else if (st_reg.dly_cnt != '0) begin
      st_next.dly_cnt = st_reg.dly_cnt - 1'b1;
      st_next.int_rst = 1'b1;
    end else begin
      st_next.int_rst = 1'b0;
    end

    // Reference is on for the detector, the comparator or the converter
    st_next.vref = drop_on | st_reg.bgsel | converter_enable;

    // Bus handshake: one wait cycle, then a single ready cycle
    st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
    if ((avs_read | avs_write) && !st_reg.ack) begin
      st_next.rdata = avs_read ? rsw_read(st_reg, avs_address, lvl2) : 32'h0;
    end
    wr = avs_write & st_reg.ack;
    wr_lo = wr & avs_byteenable[0];

    // Change window counts down; opened by writing change and enable together
    win = (st_reg.ce_cnt != 3'h0);
    if (win) begin
      st_next.ce_cnt = st_reg.ce_cnt - 3'h1;
    end

    // Watchdog control writes
    if (wr_lo && avs_address == OFS_WDCTRL) begin
      if (wd_wd[WD_CE] && wd_wd[WD_EN]) begin
        st_next.ce_cnt = CE_WINDOW;
      end
      if (wd_wd[WD_EN]) begin
        st_next.wd_en = 1'b1;
      end else if (win && !lvl2) begin
        st_next.wd_en = 1'b0;                        // Timed disable, level 1 only
      end
      if (!lvl2 || win) begin
        st_next.wd_per = wd_wd[WD_PER_LSB +: 4];     // Level 2 needs the window
      end
      st_next.wd_ie = wd_wd[WD_IE];
      if (wd_wd[WD_IF]) begin
        st_next.wd_if = 1'b0;                        // Written one clears the flag
      end
    end
    if (wr_lo && avs_address == OFS_CMPCTL) begin
      st_next.bgsel = wd_wd[CMP_BGSEL];
    end

    // Watchdog counter and time-out action
    wd_eff = st_reg.wd_en | st_reg.flags[CAUSE_WDOG] | lvl2;
    wd_run = wd_eff | st_reg.wd_ie;
    st_next.wd_pulse = 1'b0;                         // One clock only
    if (!wd_run || st_reg.int_rst || wdog_restart_instr ||
        (wr && avs_address == OFS_WDKICK)) begin
      st_next.wd_cnt = 21'h0;
    end else if (tick) begin
      timeout = (st_reg.wd_cnt >= rsw_limit(st_reg.wd_per) - 21'h1);
      st_next.wd_cnt = timeout ? 21'h0 : st_reg.wd_cnt + 21'h1;
    end
    if (timeout) begin
      if (st_reg.wd_ie) begin
        st_next.wd_if = 1'b1;
        if (wd_eff) begin
          st_next.wd_ie = 1'b0;                      // Next expiry will reset
        end
      end else begin
        st_next.wd_pulse = 1'b1;
      end
    end
    st_next.irq = st_next.wd_if & st_next.wd_ie;

    // Chip reset returns the control registers to their idle values
    if (st_reg.int_rst) begin
      st_next.wd_en = 1'b0;
      st_next.wd_ie = 1'b0;
      st_next.wd_if = 1'b0;
      st_next.wd_per = 4'h0;
      st_next.ce_cnt = 3'h0;
      st_next.bgsel = 1'b0;
      st_next.irq = 1'b0;
    end

    // Cause flags: a written zero clears, a new event wins over the clear
    if (wr_lo && avs_address == OFS_CAUSE) begin
      st_next.flags = st_reg.flags & wd_wd[3:0];
    end
    if (st_reg.wd_pulse) begin
      st_next.flags[CAUSE_WDOG] = 1'b1;
    end
    if (st_reg.drop_act) begin
      st_next.flags[CAUSE_DROP] = 1'b1;
    end
    if (st_reg.pin_act) begin
      st_next.flags[CAUSE_PIN] = 1'b1;
    end
    if (st_reg.por_s2) begin
      st_next.flags = CAUSE_RESET;                   // Power-up clears the others
    end
  end

  // State register; reset behaves as a power-up with the supply still low
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.pin_s1   <= 1'b1;
      st_reg.pin_s2   <= 1'b1;
      st_reg.por_s1   <= 1'b1;                       // Holds the source until synced
      st_reg.por_s2   <= 1'b1;
      st_reg.int_rst  <= 1'b1;
      st_reg.io_rst   <= 1'b1;
      st_reg.flags    <= CAUSE_RESET;
      st_reg.level    <= DROP_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata       = st_reg.rdata;
  assign avs_waitrequest    = ~st_reg.ack;
  assign internal_reset     = st_reg.int_rst;
  assign io_reset           = st_reg.io_rst;
  assign wdog_irq           = st_reg.irq;
  assign vref_enable        = st_reg.vref;
  assign supply_drop_enable = st_reg.drop_en;
  assign supply_drop_level  = st_reg.level;

endmodule : rsw_ctrl

// [verification/rsw_checker.sv]
/* Checker for rsw_ctrl, watching only its ports.
   Assumes the start-up delay input stays steady while reset is stretched. */
`timescale 1ns/1ps
module rsw_checker import rsw_pkg::*; #(
  parameter int unsigned DLY_W = 16
) (
  // Clock, reset and bus
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic [4:0]       avs_address,
  input wire logic             avs_read,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  // Sources and configuration
  input wire logic             reset_pin_n,
  input wire logic             supply_below_por,
  input wire logic             supply_below_trigger,
  input wire logic             converter_enable,
  input wire logic [2:0]       supply_drop_level_fuse,
  input wire logic [DLY_W-1:0] startup_delay_period,
  // Outputs
  input wire logic             internal_reset,
  input wire logic             io_reset,
  input wire logic             vref_enable,
  input wire logic             supply_drop_enable,
  input wire logic [2:0]       supply_drop_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] pin_cnt_reg, drop_cnt_reg, quiet_cnt_reg;
  logic        quiet;
  // No pin, power-up or enabled supply-drop source active; its run length times the reset stretch
  assign quiet = reset_pin_n && !supply_below_por && !(supply_below_trigger && supply_drop_enable);
  // Pin and quiet run lengths saturate so long idle spans never wrap back to small values; the drop run length wraps
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_cnt_reg   <= 16'h0000;
      drop_cnt_reg  <= 16'h0000;
      quiet_cnt_reg <= 16'h0000;
    end else begin
      pin_cnt_reg   <= reset_pin_n ? 16'h0000 : pin_cnt_reg + 16'(pin_cnt_reg != 16'hffff);
      drop_cnt_reg  <= (supply_below_trigger && supply_drop_enable) ? drop_cnt_reg + 16'h0001 : 16'h0000;
      quiet_cnt_reg <= quiet ? quiet_cnt_reg + 16'(quiet_cnt_reg != 16'hffff) : 16'h0000;
    end
  end
  sequence s_cause_read;
    avs_read && avs_address == OFS_CAUSE && !avs_waitrequest;
  endsequence
  sequence s_ref_wanted;
    (converter_enable || supply_drop_level_fuse != DROP_OFF) [*2];
  endsequence
  a_reset_state: assert property ($fell(rst) |-> internal_reset && io_reset && !vref_enable)
    else $error("reset state wrong after release");
  a_level_copy: assert property (!$past(rst) |-> supply_drop_level == $past(supply_drop_level_fuse))
    else $error("level copy differs from fuse");
  a_drop_off: assert property ($stable(supply_drop_level) |-> supply_drop_enable == (supply_drop_level != DROP_OFF))
    else $error("detector enable disagrees with level code");
  a_ref_on: assert property (s_ref_wanted |=> vref_enable)
    else $error("reference off while wanted");
  a_por_now: assert property ($rose(supply_below_por) |-> ##[1:4] (internal_reset && io_reset))
    else $error("power-up reset late");
  a_port_follow: assert property ($rose(internal_reset) |-> io_reset)
    else $error("port reset missing");
  a_cause_hi_zero: assert property (s_cause_read |-> avs_readdata[31:4] == 28'h0000000)
    else $error("reserved cause bits nonzero");
  a_pin_fire: assert property (pin_cnt_reg == 16'h0064 |-> internal_reset && io_reset)
    else $error("long pin pulse gave no reset");
  a_drop_fire: assert property (drop_cnt_reg == 16'h00d2 |-> internal_reset)
    else $error("long supply drop gave no reset");
  a_delay_hold: assert property ($past(internal_reset) && quiet
    && 32'(quiet_cnt_reg) <= 32'(startup_delay_period) |-> internal_reset)
    else $error("reset released before delay");
  a_delay_end: assert property (quiet && 32'(quiet_cnt_reg) == 32'(startup_delay_period) + 32'd16
    |-> !internal_reset)
    else $error("reset held too long");
endmodule : rsw_checker

bind rsw_ctrl rsw_checker #(.DLY_W(DLY_W)) chk_u (.mclk, .rst, .avs_address, .avs_read, .avs_readdata,
  .avs_waitrequest, .reset_pin_n, .supply_below_por, .supply_below_trigger, .converter_enable,
  .supply_drop_level_fuse, .startup_delay_period, .internal_reset, .io_reset, .vref_enable,
  .supply_drop_enable, .supply_drop_level);

// [verification/rsw_far_model.sv]
/* Far side: reset pin, supply monitors and a sped-up watchdog oscillator.
   Assumes its task is called just after a rising mclk edge. */
`timescale 1ns/1ps
module rsw_far_model (
  // System clock
  input  wire logic mclk,
  // Pin, monitors and oscillator
  output logic      reset_pin_n,
  output logic      supply_below_por,
  output logic      supply_below_trigger,
  output logic      wdog_osc_clk
);
  logic [1:0] div_reg;
  initial begin
    reset_pin_n          = 1'b1;
    supply_below_por     = 1'b0;
    supply_below_trigger = 1'b0;
    div_reg              = 2'h0;
    wdog_osc_clk         = 1'b0;
  end
  // Oscillator at a quarter of mclk, far faster than real to keep runs short
  always @(posedge mclk) begin
    div_reg      <= div_reg + 2'h1;
    wdog_osc_clk <= div_reg[1];
  end
  // Hold one source active for n clocks: 0 pin, 1 supply drop, 2 power-up
  task automatic hold(input int which, input int n);
    if (which == 0) reset_pin_n <= 1'b0;
    if (which == 1) supply_below_trigger <= 1'b1;
    if (which == 2) supply_below_por <= 1'b1;
    repeat (n) @(posedge mclk);
    reset_pin_n          <= 1'b1;
    supply_below_trigger <= 1'b0;
    supply_below_por     <= 1'b0;
  endtask : hold
endmodule : rsw_far_model

// [verification/tb_top.sv]
/* Self-checking bench for rsw_ctrl with the far-side model.
   Assumes a start-up delay of 5 clocks and the sped-up oscillator. */
`timescale 1ns/1ps
module tb_top;
  import rsw_pkg::*;
  localparam int DLY = 5;
  logic        mclk, rst, avs_read, avs_write, wdog_restart_instr, converter_enable, wdog_safety_fuse;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [2:0]  supply_drop_level_fuse, supply_drop_level;
  logic [15:0] startup_delay_period;
  logic        avs_waitrequest, reset_pin_n, supply_below_por, supply_below_trigger, wdog_osc_clk;
  logic        internal_reset, io_reset, wdog_irq, vref_enable, supply_drop_enable;
  int          mismatches, samples_checked, n;
  rsw_ctrl dut_u (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .reset_pin_n, .supply_below_por,
    .supply_below_trigger, .wdog_osc_clk, .supply_drop_level_fuse, .wdog_safety_fuse,
    .wdog_restart_instr, .converter_enable, .startup_delay_period, .internal_reset, .io_reset,
    .wdog_irq, .vref_enable, .supply_drop_enable, .supply_drop_level);
  rsw_far_model far_u (.mclk, .reset_pin_n, .supply_below_por, .supply_below_trigger, .wdog_osc_clk);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 64);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk(k < 64, 32'h1);
  endtask : bus
  // Clocks until reset is released, bounded
  task automatic wait_rel(output int k);
    k = 0;
    while (internal_reset !== 1'b0 && k < 500) begin
      @(posedge mclk);
      k++;
    end
  endtask : wait_rel
  task automatic t_power;
    wait_rel(n);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, 32'h1);
    bus(0, 5'h14, 8'h00);
    chk(rd, 32'h0);
    bus(1, OFS_CAUSE, 8'hfe);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, 32'h0);
    $display("test power done");
  endtask : t_power
  // Short then long stretch of one source; only the long one resets
  task automatic t_source(input int which, input int shrt, input int lng, input logic [31:0] flag);
    far_u.hold(which, shrt);
    repeat (4) @(posedge mclk);
    chk(internal_reset, 32'h0);
    far_u.hold(which, lng);
    chk(internal_reset, 32'h1);
    wait_rel(n);
    chk(n > DLY, 32'h1);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, flag);
    bus(1, OFS_CAUSE, 8'h00);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, 32'h0);
    $display("test source %0d done", which);
  endtask : t_source
  // Every level code, then the reference from each requester
  task automatic t_fuse;
    for (int c = 0; c < 8; c++) begin
      supply_drop_level_fuse <= 3'(c);
      repeat (3) @(posedge mclk);
      chk({supply_drop_enable, supply_drop_level, vref_enable}, {c != 7, 3'(c), c != 7});
    end
    far_u.hold(1, 300);
    chk(internal_reset, 32'h0);
    converter_enable <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(vref_enable, 32'h1);
    converter_enable <= 1'b0;
    bus(1, OFS_CMPCTL, 8'h01);
    bus(0, OFS_STATUS, 8'h00);
    chk(rd, 32'h1);
    bus(1, OFS_CMPCTL, 8'h00);
    repeat (3) @(posedge mclk);
    chk(vref_enable, 32'h0);
    supply_drop_level_fuse <= 3'h6;
    $display("test fuse done");
  endtask : t_fuse
  // Power-up after a pin reset wins and clears the pin flag
  task automatic t_por;
    far_u.hold(0, 150);
    wait_rel(n);
    far_u.hold(2, 20);
    chk(internal_reset, 32'h1);
    wait_rel(n);
    chk(n > DLY, 32'h1);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, 32'h1);
    bus(1, OFS_CAUSE, 8'h00);
    $display("test power-up done");
  endtask : t_por
  // Interrupt mode first, then reset mode with a restart midway
  task automatic t_wdog;
    bus(1, OFS_WDCTRL, 8'h02);
    n = 0;
    while (wdog_irq !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk({n > 8000 && n < 8400, internal_reset}, 32'h2);
    bus(1, OFS_WDCTRL, 8'h04);
    bus(1, OFS_WDCTRL, 8'h01);
    chk(wdog_irq, 32'h0);
    repeat (4000) @(posedge mclk);
    bus(1, OFS_WDKICK, 8'h00);
    repeat (6000) @(posedge mclk);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, 32'h0);
    wdog_restart_instr <= 1'b1;
    @(posedge mclk);
    wdog_restart_instr <= 1'b0;
    n = 0;
    while (internal_reset !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk(n > 8000 && n < 8400, 32'h1);
    wait_rel(n);
    chk(n > DLY, 32'h1);
    bus(0, OFS_CAUSE, 8'h00);
    chk(rd, 32'h8);
    bus(1, OFS_CAUSE, 8'h00);
    $display("test watchdog done");
  endtask : t_wdog
  // Level 2 refuses a free period change and the timed disable; level 1 allows both
  task automatic t_safety;
    wdog_safety_fuse <= 1'b1;
    bus(1, OFS_WDCTRL, 8'h10);
    bus(0, OFS_WDCTRL, 8'h00);
    chk(rd, 32'h1);
    bus(0, OFS_STATUS, 8'h00);
    chk(rd, 32'h7);
    bus(1, OFS_WDCTRL, 8'h09);
    bus(1, OFS_WDCTRL, 8'h00);
    wdog_safety_fuse <= 1'b0;
    bus(0, OFS_WDCTRL, 8'h00);
    chk(rd, 32'h1);
    bus(1, OFS_WDCTRL, 8'h09);
    bus(1, OFS_WDCTRL, 8'h00);
    bus(1, OFS_WDCTRL, 8'h20);
    bus(0, OFS_WDCTRL, 8'h00);
    chk(rd, 32'h20);
    $display("test safety done");
  endtask : t_safety
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    supply_drop_level_fuse = 3'h6;
    wdog_restart_instr = 1'b0;
    wdog_safety_fuse = 1'b0;
    converter_enable = 1'b0;
    startup_delay_period = 16'(DLY);
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_power;
    t_source(0, 40, 150, 32'h2);
    t_source(1, 100, 300, 32'h4);
    t_fuse;
    t_por;
    t_wdog;
    t_safety;
    close_out;
  end
  // Hang guard, about four times the expected run
  initial begin
    #1000000;
    mismatches++;
    close_out;
  end
endmodule : tb_top
